/* File: hdl/hmd_map.vh */
// Contract
// - Unsigned word divide: quotient bottom, remainder upper
// - 64-bit mode: low words, sign-extend results
// - Accumulate multiplies signed 16-bit operands, no overflow
// - Accumulate adds product into bottom register
// - Accumulate waits per prior operation hazard table
// - Signed doubleword multiply, no overflow exception
// - Product low to bottom, high to upper
// - Doubleword ops reserved in 32-bit user/supervisor
`ifndef HMD_MAP_VH
`define HMD_MAP_VH
// ------------------------------------------------------------
// Operation codes (function field values)
// ------------------------------------------------------------
`define HMD_OP_UWQUOT  6'h1B
`define HMD_OP_DWACC   6'h29
`define HMD_OP_DWPROD  6'h1C
`define HMD_OP_RDUP    6'h10
`define HMD_OP_RDBOT   6'h12
// ------------------------------------------------------------
// Hazard waits in cycles, before an accumulate may start
// ------------------------------------------------------------
`define HMD_WAIT_WMUL  7'h01
`define HMD_WAIT_DMUL  7'h04
`define HMD_WAIT_WDIV  7'h24
`define HMD_WAIT_SIGNED_DWORD_QUOTIENT_OP  7'h44
`define HMD_WAIT_READ  7'h02
`define HMD_WAIT_ACC   7'h00
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define HMD_RESULT_RST 64'h0000000000000000
`define HMD_DIV_STEPS  6'h20
`endif

/* File: hdl/hmd_divider.v */
`timescale 1ns/10ps
// Restoring 32-bit unsigned divider, one quotient bit per clock.
module hmd_divider (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        start_in,
  input  wire [31:0] dividend_in,
  input  wire [31:0] divisor_in,
  output reg         done_out,
  output reg  [31:0] quot_out,
  output reg  [31:0] rem_out
);
  `include "hmd_map.vh"
  reg  [5:0]  cnt_r;
  reg         run_r;
  reg  [31:0] dvs_r;
  // One spare bit: the shifted remainder may reach 33 bits
  wire [33:0] trial;
  assign trial = {1'b0, rem_out, quot_out[31]} - {2'b00, dvs_r};
  always @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_r    <= 6'h00;
      run_r    <= 1'b0;
      dvs_r    <= 32'h00000000;
      done_out <= 1'b0;
      quot_out <= 32'h00000000;
      rem_out  <= 32'h00000000;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        run_r    <= 1'b1;
        cnt_r    <= `HMD_DIV_STEPS;
        dvs_r    <= divisor_in;
        quot_out <= dividend_in;
        rem_out  <= 32'h00000000;
      end else if (run_r) begin
        // Zero divisor yields all-ones quotient; result undefined anyway
        if (!trial[33]) begin
          rem_out  <= trial[31:0];
          quot_out <= {quot_out[30:0], 1'b1};
        end else begin
          rem_out  <= {rem_out[30:0], quot_out[31]};
          quot_out <= {quot_out[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          run_r    <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // hmd_divider

/* File: hdl/hmd_unit.v */
`timescale 1ns/10ps
module hmd_unit (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        issue_in,
  input  wire [5:0]  op_in,
  input  wire [63:0] src_a_in,
  input  wire [63:0] src_b_in,
  input  wire        mode64_in,
  input  wire        kernel_in,
  output reg         busy_out,
  output reg         resv_exc_out,
  output reg         done_out,
  output reg  [63:0] result_upper_out,
  output reg  [63:0] result_bottom_out,
  output reg  [63:0] read_data_out
);
  `include "hmd_map.vh"

  // ------------------------------------------------------------
  // State encoding
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_DIV  = 2'b01;
  localparam ST_WAIT = 2'b10;

  // ------------------------------------------------------------
  // Sequencer and result registers
  // ------------------------------------------------------------
  reg  [1:0]   state_r;
  reg  [6:0]   hazard_r;
  reg  [6:0]   hazard_nxt;
  reg          acc_pend_r;
  reg  [63:0]  acc_a_r;
  reg  [63:0]  acc_b_r;
  reg  [63:0]  upper_r;
  reg  [63:0]  bottom_r;

  // ------------------------------------------------------------
  // Divider hand-off
  // ------------------------------------------------------------
  reg          div_go;
  wire         div_done;
  wire [31:0]  div_q;
  wire [31:0]  div_r;
  wire [63:0]  quot_ext;
  wire [63:0]  rem_ext;

  // ------------------------------------------------------------
  // Decode and arithmetic
  // ------------------------------------------------------------
  wire         idle_now;
  wire         take_now;
  wire         is_quot;
  wire         is_prod;
  wire         is_acc;
  wire         is_rd_up;
  wire         is_rd_bot;
  wire         op_ok;
  wire         dword_op;
  wire         acc_now;
  wire [127:0] dprod;
  wire [31:0]  acc_prod;
  wire [63:0]  acc_sum;
  wire [31:0]  acc_sa;
  wire [31:0]  acc_sb;
  genvar       g;

  // ------------------------------------------------------------
  // Operation decode
  // ------------------------------------------------------------
  // Requests are only looked at while idle; a request seen while
  // busy is dropped and the issuer is expected to hold it.
  assign idle_now  = (state_r == ST_IDLE);
  assign take_now  = issue_in && idle_now;
  assign is_quot   = (op_in == `HMD_OP_UWQUOT);
  assign is_prod   = (op_in == `HMD_OP_DWPROD);
  assign is_acc    = (op_in == `HMD_OP_DWACC);
  assign is_rd_up  = (op_in == `HMD_OP_RDUP);
  assign is_rd_bot = (op_in == `HMD_OP_RDBOT);

  // ------------------------------------------------------------
  // Mode check for the doubleword operations
  // ------------------------------------------------------------
  assign dword_op = is_prod || is_acc;
  assign op_ok    = mode64_in || kernel_in || !dword_op;

  // ------------------------------------------------------------
  // Signed doubleword product, single cycle
  // ------------------------------------------------------------
  // Full 128-bit product: wide, but it keeps the multiply off the
  // busy path so the result lands one cycle after issue.
  assign dprod = $signed(src_a_in) * $signed(src_b_in);

  // ------------------------------------------------------------
  // 16-bit accumulate
  // ------------------------------------------------------------
  // Only low 16 bits are used; upper bits assumed sign copies
  assign acc_sa   = {{16{acc_a_r[15]}}, acc_a_r[15:0]};
  assign acc_sb   = {{16{acc_b_r[15]}}, acc_b_r[15:0]};
  assign acc_prod = $signed(acc_sa) * $signed(acc_sb);
  assign acc_sum  = bottom_r + {{32{acc_prod[31]}}, acc_prod};
  assign acc_now  = acc_pend_r && (hazard_r == 7'h00)
                    && (state_r == ST_WAIT);

  // ------------------------------------------------------------
  // Word results widened by copying bit 31
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_ext
      if (g < 32) begin : g_low
        assign quot_ext[g] = div_q[g];
        assign rem_ext[g]  = div_r[g];
      end else begin : g_high
        assign quot_ext[g] = div_q[31];
        assign rem_ext[g]  = div_r[31];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  hmd_divider u_div (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .start_in    (div_go),
    .dividend_in (src_a_in[31:0]),
    .divisor_in  (src_b_in[31:0]),
    .done_out    (div_done),
    .quot_out    (div_q),
    .rem_out     (div_r)
  );

  // Start strobe is combinational so the divider sees the operands
  // in the same cycle as the request.
  always @* begin
    div_go = take_now && is_quot;
  end

  // ------------------------------------------------------------
  // Hazard counter: cycles an accumulate must wait
  // ------------------------------------------------------------
  always @* begin
    hazard_nxt = (hazard_r != 7'h00) ? hazard_r - 7'h01 : 7'h00;
    if (take_now && op_ok) begin
      case (op_in)
        `HMD_OP_DWPROD: hazard_nxt = `HMD_WAIT_DMUL;
        `HMD_OP_RDUP:   hazard_nxt = `HMD_WAIT_READ;
        `HMD_OP_RDBOT:  hazard_nxt = `HMD_WAIT_READ;
        // Holding one cycle is conservative; an accumulate adds none
        `HMD_OP_DWACC:  hazard_nxt = hazard_r;
        default:        hazard_nxt = hazard_nxt;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Main sequencer
  // ------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_r       <= ST_IDLE;
      hazard_r      <= 7'h00;
      acc_pend_r    <= 1'b0;
      acc_a_r       <= `HMD_RESULT_RST;
      acc_b_r       <= `HMD_RESULT_RST;
      upper_r       <= `HMD_RESULT_RST;
      bottom_r      <= `HMD_RESULT_RST;
      busy_out      <= 1'b0;
      resv_exc_out  <= 1'b0;
      done_out      <= 1'b0;
      read_data_out <= `HMD_RESULT_RST;
    end else begin
      hazard_r     <= hazard_nxt;
      resv_exc_out <= 1'b0;
      done_out     <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (issue_in && !op_ok) begin
            resv_exc_out <= 1'b1;
          end else if (issue_in) begin
            case (op_in)
              `HMD_OP_UWQUOT: begin
                state_r  <= ST_DIV;
                busy_out <= 1'b1;
              end
              `HMD_OP_DWPROD: begin
                bottom_r <= dprod[63:0];
                upper_r  <= dprod[127:64];
                done_out <= 1'b1;
              end
              `HMD_OP_DWACC: begin
                acc_a_r    <= src_a_in;
                acc_b_r    <= src_b_in;
                acc_pend_r <= 1'b1;
                state_r    <= ST_WAIT;
                busy_out   <= 1'b1;
              end
              `HMD_OP_RDUP:  read_data_out <= upper_r;
              `HMD_OP_RDBOT: read_data_out <= bottom_r;
              default: read_data_out <= read_data_out;
            endcase
          end
        end
        ST_DIV: begin
          if (div_done) begin
            // Quotient bottom, remainder upper, bit 31 extended
            bottom_r <= quot_ext;
            upper_r  <= rem_ext;
            hazard_r <= `HMD_WAIT_WDIV;
            state_r  <= ST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (acc_now) begin
            bottom_r   <= acc_sum;
            acc_pend_r <= 1'b0;
            state_r    <= ST_IDLE;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result copies for the pipeline
  // ------------------------------------------------------------
  // One cycle late by design: outputs come straight from flops, so
  // a reader must allow for the lag after each done pulse.
  always @(posedge mclk_in) begin
    if (rst_in) begin
      result_upper_out  <= `HMD_RESULT_RST;
      result_bottom_out <= `HMD_RESULT_RST;
    end else begin
      result_upper_out  <= upper_r;
      result_bottom_out <= bottom_r;
    end
  end

  // ------------------------------------------------------------
  // Usage notes
  // ------------------------------------------------------------
  // The issuer keeps two quiet slots after a result read before a
  // following multiply or divide; the unit does not check this.
  // A divide by zero gives an all-ones quotient and returns the
  // dividend as remainder; software should test the divisor.
  // The accumulate leaves the upper register as it was.
endmodule // hmd_unit

/* File: verif/hmd_unit_sva.sv */
`timescale 1ns/10ps
module hmd_unit_sva (
  input wire        mclk_in,
  input wire        rst_in,
  input wire        issue_in,
  input wire        mode64_in,
  input wire        kernel_in,
  input wire        busy_out,
  input wire        resv_exc_out,
  input wire        done_out,
  input wire [5:0]  op_in,
  input wire [63:0] src_a_in,
  input wire [63:0] src_b_in,
  input wire [63:0] result_upper_out,
  input wire [63:0] result_bottom_out,
  input wire [63:0] read_data_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire tk = issue_in && !busy_out;
  wire ok = mode64_in || kernel_in;
  property p_div_end; tk && op_in == 6'h1B |-> ##[33:34] done_out; endproperty
  a_div_end: assert property (p_div_end)
    else $error("divide end late");
  property p_div_sx;
    tk && op_in == 6'h1B && mode64_in |-> ##[33:34] done_out ##1
    (result_bottom_out[63:32] == {32{result_bottom_out[31]}} &&
     result_upper_out[63:32] == {32{result_upper_out[31]}});
  endproperty
  a_div_sx: assert property (p_div_sx)
    else $error("divide result not sign extended");
  property p_div_busy; tk && op_in == 6'h1B |=> busy_out [*8]; endproperty
  a_div_busy: assert property (p_div_busy)
    else $error("busy dropped during divide");
  property p_mul_done; tk && op_in == 6'h1C && ok |=> done_out; endproperty
  a_mul_done: assert property (p_mul_done)
    else $error("multiply done missing");
  property p_mul_resv;
    tk && op_in == 6'h1C && !ok |=> resv_exc_out && !done_out;
  endproperty
  a_mul_resv: assert property (p_mul_resv)
    else $error("illegal multiply not refused");
  property p_mac_wait;
    tk && op_in == 6'h29 && ok |=> !done_out ##[1:40] done_out;
  endproperty
  a_mac_wait: assert property (p_mac_wait)
    else $error("accumulate timing wrong");
  property p_rd_bot;
    tk && op_in == 6'h12 |-> ##2 read_data_out == result_bottom_out;
  endproperty
  a_rd_bot: assert property (p_rd_bot)
    else $error("bottom read wrong");
  property p_busy_ign; busy_out && issue_in |=> !resv_exc_out; endproperty
  a_busy_ign: assert property (p_busy_ign)
    else $error("request taken while busy");
endmodule // hmd_unit_sva
bind hmd_unit hmd_unit_sva u_sva (
  .mclk_in           (mclk_in),
  .rst_in            (rst_in),
  .issue_in          (issue_in),
  .mode64_in         (mode64_in),
  .kernel_in         (kernel_in),
  .busy_out          (busy_out),
  .resv_exc_out      (resv_exc_out),
  .done_out          (done_out),
  .op_in             (op_in),
  .src_a_in          (src_a_in),
  .src_b_in          (src_b_in),
  .result_upper_out  (result_upper_out),
  .result_bottom_out (result_bottom_out),
  .read_data_out     (read_data_out)
);

/* File: verif/hmd_issuer.sv */
`timescale 1ns/10ps
module hmd_issuer (
  input  wire        mclk_in,
  input  wire        busy_in,
  output reg         issue_out,
  output reg         mode64_out,
  output reg         kernel_out,
  output reg  [5:0]  op_out,
  output reg  [63:0] src_a_out,
  output reg  [63:0] src_b_out
);
  initial {issue_out, mode64_out, kernel_out, op_out} = 9'h000;
  initial {src_a_out, src_b_out} = 128'h0;
  // Request held until the unit is seen idle at an edge
  task send(input [5:0] op, input [63:0] a, b, input m64, krn);
    begin
      issue_out <= 1'b1;
      op_out <= op;
      src_a_out <= a;
      src_b_out <= b;
      mode64_out <= m64;
      kernel_out <= krn;
      @(posedge mclk_in);
      while (busy_in !== 1'b0) @(posedge mclk_in);
      issue_out <= 1'b0;
      src_a_out <= ~a;
      src_b_out <= ~b;
      @(posedge mclk_in);
      // Quiet slots after a read keep later writes defined
      if (op == 6'h10 || op == 6'h12) repeat (2) @(posedge mclk_in);
    end
  endtask
endmodule // hmd_issuer

/* File: verif/test_hilo_multiply_divide_unit.sv */
`timescale 1ns/10ps
module test_hilo_multiply_divide_unit;
  reg          mclk_in = 1'b0;
  reg          rst_in = 1'b1;
  wire         issue, busy, resv, done, m64, krn;
  wire [5:0]   op;
  wire [63:0]  sa, sb, up, bot, rdd;
  reg  [128:0] q[$];
  reg  [128:0] e;
  reg  [63:0]  a, b, bot_m;
  reg  [127:0] p;
  reg  [31:0]  x = 32'h4DC958A3;
  reg          pend = 1'b0;
  integer      n_fail = 0, compares = 0, n_resv = 0, i;
  hmd_unit u_hmd_unit (.mclk_in(mclk_in), .rst_in(rst_in), .issue_in(issue),
    .op_in(op), .src_a_in(sa), .src_b_in(sb), .mode64_in(m64),
    .kernel_in(krn), .busy_out(busy), .resv_exc_out(resv), .done_out(done),
    .result_upper_out(up), .result_bottom_out(bot), .read_data_out(rdd));
  hmd_issuer u_hmd_issuer (.mclk_in(mclk_in), .busy_in(busy),
    .issue_out(issue), .mode64_out(m64), .kernel_out(krn), .op_out(op),
    .src_a_out(sa), .src_b_out(sb));
  initial forever #12.5 mclk_in = ~mclk_in;
  function [31:0] rnd();
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      rnd = x;
    end
  endfunction
  task chk(input [63:0] g, input [63:0] w);
    begin
      compares = compares + 1;
      if (g !== w) begin
        n_fail = n_fail + 1;
        $display("unexpected t=%0t got %h exp %h", $time, g, w);
      end
    end
  endtask
  task test_done;
    begin
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Each result is compared one edge after its done pulse
  always @(posedge mclk_in) begin
    if (resv === 1'b1) n_resv = n_resv + 1;
    if (pend) begin
      e = q.pop_front();
      chk(bot, e[63:0]);
      if (e[128]) chk(up, e[127:64]);
    end
    pend = (done === 1'b1);
  end
  initial begin
    #500000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    for (i = 0; i < 6; i = i + 1) begin
      a = {rnd(), rnd()};
      b = {rnd(), rnd() | 32'h00000001};
      p[63:0] = {32'h0, a[31:0] / b[31:0]};
      p[127:64] = {32'h0, a[31:0] % b[31:0]};
      bot_m = {{32{p[31]}}, p[31:0]};
      q.push_back({1'b1, {32{p[95]}}, p[95:64], bot_m});
      u_hmd_issuer.send(6'h1B, a, b, 1'b1, 1'b0);
      a = {rnd(), rnd()};
      b = {rnd(), rnd()};
      p = $signed(a) * $signed(b);
      bot_m = p[63:0];
      q.push_back({1'b1, p});
      u_hmd_issuer.send(6'h1C, a, b, i[0], 1'b1);
      p[31:0] = rnd();
      a = {{49{p[14]}}, p[14:0]};
      b = {{49{p[30]}}, p[30:16]};
      p = $signed(a[15:0]) * $signed(b[15:0]);
      bot_m = bot_m + p[63:0];
      q.push_back({1'b0, 64'h0, bot_m});
      u_hmd_issuer.send(6'h29, a, b, 1'b1, 1'b0);
      u_hmd_issuer.send(i[0] ? 6'h29 : 6'h1C, a, b, 1'b0, 1'b0);
      while (q.size() != 0) @(posedge mclk_in);
      u_hmd_issuer.send(6'h12, 64'h0, 64'h0, 1'b1, 1'b0);
      chk(rdd, bot_m);
    end
    chk(n_resv, 64'h6);
    test_done;
  end
endmodule // test_hilo_multiply_divide_unit
